// file: hw/cocr_pkg.sv
// Register map, field layout and reset values of the clock output control block
package cocr_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_FB_LOW_SET3   = 8'h67;  // Third PLL feedback low byte, set 3
  localparam logic [7:0] ADDR_SSFB_SET0     = 8'h68;  // Spread loop count low byte, set 0
  localparam logic [7:0] ADDR_SSFB_SET1     = 8'h69;  // Spread loop count low byte, set 1
  localparam logic [7:0] ADDR_SSFB_SET2     = 8'h6A;  // Spread loop count low byte, set 2
  localparam logic [7:0] ADDR_SSFB_SET3     = 8'h6B;  // Spread loop count low byte, set 3
  localparam logic [7:0] ADDR_SSFB_SET4     = 8'h6C;  // Spread loop count low byte, set 4
  localparam logic [7:0] ADDR_SSFB_SET5     = 8'h6D;  // Spread loop count low byte, set 5
  localparam logic [7:0] ADDR_SSRD_SET4     = 8'h6E;  // Spread reference divide, set 4
  localparam logic [7:0] ADDR_SSRD_SET5     = 8'h6F;  // Spread reference divide, set 5
  localparam logic [7:0] ADDR_SSRD_SET0     = 8'h70;  // Spread reference divide, set 0
  localparam logic [7:0] ADDR_SSRD_SET1     = 8'h71;  // Spread reference divide, set 1
  localparam logic [7:0] ADDR_SSRD_SET2     = 8'h72;  // Spread reference divide, set 2
  localparam logic [7:0] ADDR_RSVD_73       = 8'h73;  // Reserved, constant read value
  localparam logic [7:0] ADDR_OUT0_ROUTE    = 8'h74;  // Output 0 control and routing
  localparam logic [7:0] ADDR_OUT12         = 8'h76;  // Outputs 1 and 2 control
  localparam logic [7:0] ADDR_OUTPUT2_SLEW_CTRL         = 8'h77;  // Output 2 slew
  localparam logic [7:0] ADDR_OUT36         = 8'h78;  // Outputs 3 and 6 control
  localparam logic [7:0] ADDR_OUT4          = 8'h79;  // Output 4 pair control
  localparam logic [7:0] ADDR_OUT5          = 8'h7A;  // Output 5 pair control
  localparam logic [7:0] ADDR_OUTPUT6_SLEW_CTRL         = 8'h7B;  // Output 6 slew

  // Reset values
  localparam logic [7:0] RST_FB_LOW         = 8'h0C;
  localparam logic [7:0] RST_SS             = 8'h00;
  localparam logic [7:0] RST_RSVD_73        = 8'h01;
  localparam logic [7:0] RST_OUT0_ROUTE     = 8'h03;
  localparam logic [7:0] RST_CTRL           = 8'h00;

  // Writable bit masks, reserved bits read zero
  localparam logic [7:0] MASK_OUT0_ROUTE    = 8'hFB;
  localparam logic [7:0] MASK_PAIR          = 8'hFC;
  localparam logic [7:0] MASK_OUTPUT2_SLEW_CTRL         = 8'h30;
  localparam logic [7:0] MASK_OUTPUT6_SLEW_CTRL         = 8'hC0;

  // Field positions
  localparam int OEM_HI                     = 7;
  localparam int OEM_LO                     = 6;
  localparam int SLEW_HI                    = 5;
  localparam int SLEW_LO                    = 4;
  localparam int INV0_BIT                   = 3;
  localparam int INV_FIRST_BIT              = 3;  // First output of a pair
  localparam int INV_SECOND_BIT             = 2;  // Second output of a pair
  localparam int S1_BIT                     = 1;
  localparam int S3_BIT                     = 0;
  localparam int OUTPUT6_SLEW_CTRL_HI                   = 7;
  localparam int OUTPUT6_SLEW_CTRL_LO                   = 6;

  // Configuration sets and divider limits
  localparam int NUM_SETS                   = 6;
  localparam logic [11:0] FB_MIN            = 12'h00C;  // Least legal feedback count, 12
  localparam logic [11:0] FB_MAX            = 12'hFFF;  // Largest legal feedback count, 4095

endpackage

// file: hw/cocr_top.sv
// Clock output control registers, spread-spectrum set storage and output stage
// Functional notes
// - Source select one: outputs 1,2 from dividers 1,2
// - Source select zero: outputs 1,2 from divider 2
// - Second select one: outputs 3,6 from dividers 3,6
// - Second select zero: outputs 3,6 from divider 6
// - Enable mode with enable pin low: x0 float, 01 low, 11 high
// - Register 0x74 mode governs output 0 only
// - Second control register mode governs outputs 1,2
// - Invert bit one presents inverted clock
// - Register 0x78 mode governs outputs 3,6
// - Register 0x79 mode governs outputs 4,4b
// - Register 0x7A mode governs outputs 5,5b
// - Six spread loop count low bytes held
// - Full spread count joins upper byte registers
// - Five spread reference divide bytes held, set 3 fixed at zero
// - Feedback divider limited to 12 through 4095
`timescale 1ns/1ps
`default_nettype none

module cocr_top #(
  parameter int SYNC_STAGES = 3  // Pin synchroniser depth
) (
  input  wire logic        CLK,              // 200 MHz register clock
  input  wire logic        SRST,             // Synchronous reset, active high
  // Register port from the serial host logic
  input  wire logic [7:0]  REG_ADDR,         // Register offset
  input  wire logic        REG_WR,           // Write strobe
  input  wire logic [7:0]  REG_WDATA,        // Write data
  input  wire logic        REG_RD,           // Read strobe
  output logic      [7:0]  REG_RDATA,        // Read data, one cycle after strobe
  output logic             REG_RVALID,       // Read data valid pulse
  // Active set and upper bytes held outside
  input  wire logic [2:0]  CFG_SEL,          // Active configuration set
  input  wire logic [7:0]  SS_FB_HIGH,       // Upper spread count byte of active set
  input  wire logic [3:0]  FB_HIGH_SET3,     // Upper feedback bits of set 3
  output logic      [15:0] SS_LOOP_COUNT,    // Spread loop count to PLL
  output logic      [7:0]  SS_REF_DIV,       // Spread reference divide to PLL
  output logic      [11:0] FB_COUNT_SET3,    // Legal feedback count of set 3
  output logic             FB_SET3_CLAMPED,  // Programmed count was illegal
  // Global output enable pin
  input  wire logic        OUT_EN_PIN,       // High lets clocks run
  // Divider clocks
  input  wire logic        DIV0_CLK,         // Source of output 0
  input  wire logic        DIV1_CLK,
  input  wire logic        DIV2_CLK,
  input  wire logic        DIV3_CLK,
  input  wire logic        DIV6_CLK,
  input  wire logic        DIV4_CLK,
  input  wire logic        DIV5_CLK,
  // Output pins, enable low while driving
  output logic             OUT0,
  output logic             OUT0_OE_N,
  output logic             OUT1,
  output logic             OUT1_OE_N,
  output logic             OUT2,
  output logic             OUT2_OE_N,
  output logic             OUT3,
  output logic             OUT3_OE_N,
  output logic             OUT4,
  output logic             OUT4_OE_N,
  output logic             OUT4B,
  output logic             OUT4B_OE_N,
  output logic             OUT5,
  output logic             OUT5_OE_N,
  output logic             OUT5B,
  output logic             OUT5B_OE_N,
  output logic             OUT6,
  output logic             OUT6_OE_N,
  // Slew settings to pad drivers
  output logic      [1:0]  SLEW0,
  output logic      [1:0]  SLEW1,
  output logic      [1:0]  OUTPUT2_SLEW_CTRL,
  output logic      [1:0]  SLEW3,
  output logic      [1:0]  SLEW4,
  output logic      [1:0]  SLEW5,
  output logic      [1:0]  OUTPUT6_SLEW_CTRL
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  ////////////////////////////////////////////////////////////////////////////

  // Two agreeing stages after the first are needed
  if (SYNC_STAGES != 3) begin : g_bad_sync
    $error("SYNC_STAGES must be 3");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] fb_low_set3_r;                       // Feedback low byte, set 3
  logic [7:0] ss_fb_low_r [cocr_pkg::NUM_SETS];    // Spread loop count low bytes
  logic [7:0] ss_refdiv_r [cocr_pkg::NUM_SETS];    // Spread reference divides
  logic [7:0] out0_route_r;                        // Output 0 and routing
  logic [7:0] out12_r;                             // Outputs 1 and 2
  logic [7:0] output2_slew_ctrl_r;                             // Output 2 slew
  logic [7:0] out36_r;                             // Outputs 3 and 6
  logic [7:0] out4_r;                              // Output 4 pair
  logic [7:0] out5_r;                              // Output 5 pair
  logic [7:0] output6_slew_ctrl_r;                             // Output 6 slew

  // Feedback low byte of set 3
  always_ff @(posedge CLK) begin
    if (SRST) begin
      fb_low_set3_r <= cocr_pkg::RST_FB_LOW;
    end else if (REG_WR && REG_ADDR == cocr_pkg::ADDR_FB_LOW_SET3) begin
      fb_low_set3_r <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int i = 0; i < cocr_pkg::NUM_SETS; i++) begin
        ss_fb_low_r[i] <= cocr_pkg::RST_SS;
      end
    end else if (REG_WR) begin
      // Sets sit at consecutive offsets
      case (REG_ADDR)
        cocr_pkg::ADDR_SSFB_SET0: ss_fb_low_r[0] <= REG_WDATA;
        cocr_pkg::ADDR_SSFB_SET1: ss_fb_low_r[1] <= REG_WDATA;
        cocr_pkg::ADDR_SSFB_SET2: ss_fb_low_r[2] <= REG_WDATA;
        cocr_pkg::ADDR_SSFB_SET3: ss_fb_low_r[3] <= REG_WDATA;
        cocr_pkg::ADDR_SSFB_SET4: ss_fb_low_r[4] <= REG_WDATA;
        cocr_pkg::ADDR_SSFB_SET5: ss_fb_low_r[5] <= REG_WDATA;
        default: ;  // Other offsets leave these alone
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int i = 0; i < cocr_pkg::NUM_SETS; i++) begin
        ss_refdiv_r[i] <= cocr_pkg::RST_SS;
      end
    end else if (REG_WR) begin
      // Set 3 has no offset and keeps its reset value
      case (REG_ADDR)
        cocr_pkg::ADDR_SSRD_SET0: ss_refdiv_r[0] <= REG_WDATA;
        cocr_pkg::ADDR_SSRD_SET1: ss_refdiv_r[1] <= REG_WDATA;
        cocr_pkg::ADDR_SSRD_SET2: ss_refdiv_r[2] <= REG_WDATA;
        cocr_pkg::ADDR_SSRD_SET4: ss_refdiv_r[4] <= REG_WDATA;
        cocr_pkg::ADDR_SSRD_SET5: ss_refdiv_r[5] <= REG_WDATA;
        default: ;  // Other offsets leave these alone
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      out0_route_r <= cocr_pkg::RST_OUT0_ROUTE;
      out12_r      <= cocr_pkg::RST_CTRL;
      output2_slew_ctrl_r      <= cocr_pkg::RST_CTRL;
      out36_r      <= cocr_pkg::RST_CTRL;
      out4_r       <= cocr_pkg::RST_CTRL;
      out5_r       <= cocr_pkg::RST_CTRL;
      output6_slew_ctrl_r      <= cocr_pkg::RST_CTRL;
    end else if (REG_WR) begin
      // Reserved bits stay zero
      case (REG_ADDR)
        cocr_pkg::ADDR_OUT0_ROUTE: out0_route_r <= REG_WDATA & cocr_pkg::MASK_OUT0_ROUTE;
        cocr_pkg::ADDR_OUT12:      out12_r      <= REG_WDATA & cocr_pkg::MASK_PAIR;
        cocr_pkg::ADDR_OUTPUT2_SLEW_CTRL:      output2_slew_ctrl_r      <= REG_WDATA & cocr_pkg::MASK_OUTPUT2_SLEW_CTRL;
        cocr_pkg::ADDR_OUT36:      out36_r      <= REG_WDATA & cocr_pkg::MASK_PAIR;
        cocr_pkg::ADDR_OUT4:       out4_r       <= REG_WDATA & cocr_pkg::MASK_PAIR;
        cocr_pkg::ADDR_OUT5:       out5_r       <= REG_WDATA & cocr_pkg::MASK_PAIR;
        cocr_pkg::ADDR_OUTPUT6_SLEW_CTRL:      output6_slew_ctrl_r      <= REG_WDATA & cocr_pkg::MASK_OUTPUT6_SLEW_CTRL;
        default: ;  // Unmapped writes ignored
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read
  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] rd_mux;  // Combinational read selection

  // Read selection, unmapped offsets read zero
  always_comb begin
    case (REG_ADDR)
      cocr_pkg::ADDR_FB_LOW_SET3: rd_mux = fb_low_set3_r;
      cocr_pkg::ADDR_SSFB_SET0:   rd_mux = ss_fb_low_r[0];
      cocr_pkg::ADDR_SSFB_SET1:   rd_mux = ss_fb_low_r[1];
      cocr_pkg::ADDR_SSFB_SET2:   rd_mux = ss_fb_low_r[2];
      cocr_pkg::ADDR_SSFB_SET3:   rd_mux = ss_fb_low_r[3];
      cocr_pkg::ADDR_SSFB_SET4:   rd_mux = ss_fb_low_r[4];
      cocr_pkg::ADDR_SSFB_SET5:   rd_mux = ss_fb_low_r[5];
      cocr_pkg::ADDR_SSRD_SET0:   rd_mux = ss_refdiv_r[0];
      cocr_pkg::ADDR_SSRD_SET1:   rd_mux = ss_refdiv_r[1];
      cocr_pkg::ADDR_SSRD_SET2:   rd_mux = ss_refdiv_r[2];
      cocr_pkg::ADDR_SSRD_SET4:   rd_mux = ss_refdiv_r[4];
      cocr_pkg::ADDR_SSRD_SET5:   rd_mux = ss_refdiv_r[5];
      cocr_pkg::ADDR_RSVD_73:     rd_mux = cocr_pkg::RST_RSVD_73;
      cocr_pkg::ADDR_OUT0_ROUTE:  rd_mux = out0_route_r;
      cocr_pkg::ADDR_OUT12:       rd_mux = out12_r;
      cocr_pkg::ADDR_OUTPUT2_SLEW_CTRL:       rd_mux = output2_slew_ctrl_r;
      cocr_pkg::ADDR_OUT36:       rd_mux = out36_r;
      cocr_pkg::ADDR_OUT4:        rd_mux = out4_r;
      cocr_pkg::ADDR_OUT5:        rd_mux = out5_r;
      cocr_pkg::ADDR_OUTPUT6_SLEW_CTRL:       rd_mux = output6_slew_ctrl_r;
      default:                    rd_mux = 8'h00;
    endcase
  end

  // Read data captured on the strobe, held until next read
  always_ff @(posedge CLK) begin
    if (SRST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rd_mux;
    end
  end

  // Read valid pulse
  always_ff @(posedge CLK) begin
    if (SRST) begin
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active set spread values and set 3 feedback count to the third PLL
  ////////////////////////////////////////////////////////////////////////////

  logic [2:0] set_idx;  // Legal set index

  // Out of range selections fall back to set 0
  always_comb begin
    if (CFG_SEL < 3'(cocr_pkg::NUM_SETS)) begin
      set_idx = CFG_SEL;
    end else begin
      set_idx = 3'h0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      SS_LOOP_COUNT <= 16'h0000;
      SS_REF_DIV    <= 8'h00;
    end else begin
      // Upper byte joined above low byte
      SS_LOOP_COUNT <= {SS_FB_HIGH, ss_fb_low_r[set_idx]};
      SS_REF_DIV    <= ss_refdiv_r[set_idx];
    end
  end

  logic [11:0] fb_raw;  // Programmed feedback count of set 3

  assign fb_raw = {FB_HIGH_SET3, fb_low_set3_r};

  // Illegal small counts clamped to least legal
  always_ff @(posedge CLK) begin
    if (SRST) begin
      FB_COUNT_SET3   <= cocr_pkg::FB_MIN;
      FB_SET3_CLAMPED <= 1'b0;
    end else if (fb_raw < cocr_pkg::FB_MIN) begin
      FB_COUNT_SET3   <= cocr_pkg::FB_MIN;
      FB_SET3_CLAMPED <= 1'b1;
    end else begin
      FB_COUNT_SET3   <= fb_raw;
      FB_SET3_CLAMPED <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable pin synchroniser
  ////////////////////////////////////////////////////////////////////////////

  logic [SYNC_STAGES-1:0] en_sync_r;  // Pin shift chain
  logic                   run_r;      // Filtered enable level

  // Three stage chain; first stage feeds only the second
  always_ff @(posedge CLK) begin
    if (SRST) begin
      en_sync_r <= '0;
    end else begin
      en_sync_r <= {en_sync_r[SYNC_STAGES-2:0], OUT_EN_PIN};
    end
  end

  // Level changes once stages two and three agree
  always_ff @(posedge CLK) begin
    if (SRST) begin
      run_r <= 1'b0;
    end else if (en_sync_r[1] == en_sync_r[2]) begin
      run_r <= en_sync_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage
  ////////////////////////////////////////////////////////////////////////////

  // Drive one pin: returns {level, oe_n}
  function automatic logic [1:0] pin_drive(input logic clk_in, input logic [1:0] mode,
                                           input logic polarity_flip, input logic run);
    logic [1:0] res;
    res = 2'b01;
    if (run) begin
      // Polarity flip on the running clock
      res = {clk_in ^ polarity_flip, 1'b0};
    end else if (mode[0]) begin
      // Parked at the level in the high mode bit
      res = {mode[1], 1'b0};
    end else begin
      // Mode x0 floats the pin
      res = 2'b01;
    end
    return res;
  endfunction

  logic src1;  // Routed source of output 1
  logic src3;  // Routed source of output 3

  assign src1 = out0_route_r[cocr_pkg::S1_BIT] ? DIV1_CLK : DIV2_CLK;
  assign src3 = out0_route_r[cocr_pkg::S3_BIT] ? DIV3_CLK : DIV6_CLK;

  logic [1:0] mode0, mode12, mode36, mode4, mode5;  // Enable modes per field

  assign mode0  = out0_route_r[cocr_pkg::OEM_HI:cocr_pkg::OEM_LO];
  assign mode12 = out12_r[cocr_pkg::OEM_HI:cocr_pkg::OEM_LO];
  assign mode36 = out36_r[cocr_pkg::OEM_HI:cocr_pkg::OEM_LO];
  assign mode4  = out4_r[cocr_pkg::OEM_HI:cocr_pkg::OEM_LO];
  assign mode5  = out5_r[cocr_pkg::OEM_HI:cocr_pkg::OEM_LO];

  // Clock paths stay combinational so no edge is resampled at 200 MHz
  // Output 0 mode alone
  assign {OUT0, OUT0_OE_N} = pin_drive(DIV0_CLK, mode0,
                                       out0_route_r[cocr_pkg::INV0_BIT], run_r);
  // Outputs 1 and 2 share one mode
  assign {OUT1, OUT1_OE_N} = pin_drive(src1, mode12,
                                       out12_r[cocr_pkg::INV_FIRST_BIT], run_r);
  assign {OUT2, OUT2_OE_N} = pin_drive(DIV2_CLK, mode12,
                                       out12_r[cocr_pkg::INV_SECOND_BIT], run_r);
  // Outputs 3 and 6 share one mode
  assign {OUT3, OUT3_OE_N} = pin_drive(src3, mode36,
                                       out36_r[cocr_pkg::INV_FIRST_BIT], run_r);
  assign {OUT6, OUT6_OE_N} = pin_drive(DIV6_CLK, mode36,
                                       out36_r[cocr_pkg::INV_SECOND_BIT], run_r);
  assign {OUT4, OUT4_OE_N} = pin_drive(DIV4_CLK, mode4,
                                       out4_r[cocr_pkg::INV_FIRST_BIT], run_r);
  assign {OUT4B, OUT4B_OE_N} = pin_drive(~DIV4_CLK, mode4,
                                         out4_r[cocr_pkg::INV_SECOND_BIT], run_r);
  assign {OUT5, OUT5_OE_N} = pin_drive(DIV5_CLK, mode5,
                                       out5_r[cocr_pkg::INV_FIRST_BIT], run_r);
  assign {OUT5B, OUT5B_OE_N} = pin_drive(~DIV5_CLK, mode5,
                                         out5_r[cocr_pkg::INV_SECOND_BIT], run_r);

  // Slew fields straight from registers
  assign SLEW0 = out0_route_r[cocr_pkg::SLEW_HI:cocr_pkg::SLEW_LO];
  assign SLEW1 = out12_r[cocr_pkg::SLEW_HI:cocr_pkg::SLEW_LO];
  assign OUTPUT2_SLEW_CTRL = output2_slew_ctrl_r[cocr_pkg::SLEW_HI:cocr_pkg::SLEW_LO];
  assign SLEW3 = out36_r[cocr_pkg::SLEW_HI:cocr_pkg::SLEW_LO];
  assign SLEW4 = out4_r[cocr_pkg::SLEW_HI:cocr_pkg::SLEW_LO];
  assign SLEW5 = out5_r[cocr_pkg::SLEW_HI:cocr_pkg::SLEW_LO];
  assign OUTPUT6_SLEW_CTRL = output6_slew_ctrl_r[cocr_pkg::OUTPUT6_SLEW_CTRL_HI:cocr_pkg::OUTPUT6_SLEW_CTRL_LO];

endmodule

`default_nettype wire

// file: testbench/cocr_chk.sv
// Concurrent checks on the clock output control ports
`timescale 1ns/1ps
`default_nettype none
module cocr_chk (
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic [7:0]  REG_ADDR,
  input wire logic        REG_WR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_RDATA,
  input wire logic        REG_RVALID,
  input wire logic [3:0]  FB_HIGH_SET3,
  input wire logic [11:0] FB_COUNT_SET3,
  input wire logic        OUT0,
  input wire logic        OUT0_OE_N,
  input wire logic        OUT1_OE_N,
  input wire logic        OUT2_OE_N,
  input wire logic        OUT3_OE_N,
  input wire logic        OUT6_OE_N,
  input wire logic        OUT4_OE_N,
  input wire logic        OUT4B_OE_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  ////////////////////////////////////////////////////////////////////////////
  // Write of a low byte, then its read
  sequence s_wr_low;
    REG_WR && REG_ADDR == 8'h68;
  endsequence
  sequence s_rd_low;
    REG_RD && !REG_WR && REG_ADDR == 8'h68;
  endsequence
  // Short low byte with zero upper bits
  sequence s_wr_short;
    REG_WR && REG_ADDR == 8'h67 && REG_WDATA < 8'h0C && FB_HIGH_SET3 == 4'h0 ##1 FB_HIGH_SET3 == 4'h0;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (REG_RD |=> REG_RVALID)
    else $error("read not answered");
  a_low_readback: assert property (s_wr_low ##1 s_rd_low |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("low byte readback differs");
  a_fb_floor: assert property (FB_COUNT_SET3 >= 12'h00C)
    else $error("feedback count below floor");
  a_fb_clamp: assert property (s_wr_short |=> FB_COUNT_SET3 == 12'h00C)
    else $error("short count not clamped");
  a_pair12_oe: assert property (OUT1_OE_N == OUT2_OE_N)
    else $error("outputs 1 and 2 enables differ");
  a_pair36_oe: assert property (OUT3_OE_N == OUT6_OE_N)
    else $error("outputs 3 and 6 enables differ");
  a_pair4_oe: assert property (OUT4_OE_N == OUT4B_OE_N)
    else $error("output 4 pair enables differ");
  a_float_low: assert property (OUT0_OE_N |-> !OUT0)
    else $error("floating output not low");
endmodule
bind cocr_top cocr_chk u_chk (.*);
`default_nettype wire

// file: testbench/cocr_sink.sv
// Downstream receiver model resolving each output clock line
`timescale 1ns/1ps
`default_nettype none
module cocr_sink (
  input  wire logic [8:0] pin_out,   // Levels offered
  input  wire logic [8:0] pin_oe_n,  // Low while driven
  output logic      [8:0] line       // Level on each line
);
  logic [8:0] last_r;  // Last driven level
  // Released line shows no stale value
  always @* begin
    for (int i = 0; i < 9; i++) begin
      if (pin_oe_n[i] === 1'h0) begin
        last_r[i] = pin_out[i];
      end
      line[i] = (pin_oe_n[i] === 1'h0) ? pin_out[i] : ~last_r[i];
    end
  end
endmodule
`default_nettype wire

// file: testbench/cocr_tb_top.sv
// Self-checking testbench of the clock output control block
`timescale 1ns/1ps
`default_nettype none
module cocr_tb_top;
  logic CLK = 1'h0, SRST = 1'h1, REG_WR = 1'h0, REG_RD = 1'h0, OUT_EN_PIN = 1'h0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, SS_FB_HIGH = 8'h00;
  logic [2:0] CFG_SEL = 3'h0;
  logic [3:0] FB_HIGH_SET3 = 4'h0;
  logic DIV0_CLK = 1'h0, DIV1_CLK = 1'h0, DIV2_CLK = 1'h0, DIV3_CLK = 1'h0;
  logic DIV4_CLK = 1'h0, DIV5_CLK = 1'h0, DIV6_CLK = 1'h0;
  wire logic [7:0] REG_RDATA, SS_REF_DIV;
  wire logic [15:0] SS_LOOP_COUNT;
  wire logic [11:0] FB_COUNT_SET3;
  wire logic REG_RVALID, FB_SET3_CLAMPED, OUT0, OUT1, OUT2, OUT3, OUT4, OUT4B, OUT5, OUT5B, OUT6;
  wire logic OUT0_OE_N, OUT1_OE_N, OUT2_OE_N, OUT3_OE_N, OUT4_OE_N, OUT4B_OE_N;
  wire logic OUT5_OE_N, OUT5B_OE_N, OUT6_OE_N;
  wire logic [1:0] SLEW0, SLEW1, OUTPUT2_SLEW_CTRL, SLEW3, SLEW4, SLEW5, OUTPUT6_SLEW_CTRL;
  wire logic [8:0] pin_o = {OUT0, OUT1, OUT2, OUT3, OUT6, OUT4, OUT4B, OUT5, OUT5B};
  wire logic [8:0] pin_n = {OUT0_OE_N, OUT1_OE_N, OUT2_OE_N, OUT3_OE_N, OUT6_OE_N,
                            OUT4_OE_N, OUT4B_OE_N, OUT5_OE_N, OUT5B_OE_N};
  wire logic [8:0] line;                 // Lines seen downstream
  int failures = 0, check_count = 0;     // Run counters
  int seed = 32'h3DB0;                   // Fixed random seed
  logic [7:0] expq [$];                  // Expected read data
  cocr_top i_dut (.*);
  cocr_sink i_sink (.pin_out(pin_o), .pin_oe_n(pin_n), .line(line));
  always #2.5 CLK = ~CLK;
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus cycle, strobes stay up
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    REG_WR = w;
    REG_RD = ~w;
    REG_ADDR = a;
    REG_WDATA = d;
    if (!w) expq.push_back(e);
    @(posedge CLK);
    #1;
  endtask
  // Idle cycles, strobes down
  task automatic idle(input int n);
    repeat (n) begin
      REG_WR = 1'h0;
      REG_RD = 1'h0;
      @(posedge CLK);
      #1;
    end
  endtask
  // Writable bits per offset
  function automatic logic [7:0] rmask(input logic [7:0] a);
    if (a <= 8'h72) return 8'hFF;
    if (a == 8'h74) return 8'hFB;
    if (a == 8'h77) return 8'h30;
    if (a == 8'h7B) return 8'hC0;
    return (a == 8'h73 || a == 8'h75) ? 8'h00 : 8'hFC;
  endfunction
  task automatic finish_test;
    // Reads never answered add one failure in total
    if (expq.size() != 0) failures++;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Read results taken oldest first
  always @(negedge CLK) begin
    if (REG_RVALID === 1'h1) begin
      if (expq.size() == 0) failures++;
      else check({8'h00, REG_RDATA}, {8'h00, expq.pop_front()});
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] a, d, lo [6], rd [6], ctl [5];
    logic [8:0] gm [5], r, eo, en;
    logic [1:0] s;
    ctl = '{8'h74, 8'h76, 8'h78, 8'h79, 8'h7A};
    gm = '{9'h100, 9'h0C0, 9'h030, 9'h00C, 9'h003};
    repeat (5) @(posedge CLK);
    #1 SRST = 1'h0;
    // Reset values, then back-to-back write and read
    for (int i = 8'h67; i <= 8'h7B; i++) begin
      a = i[7:0];
      bus(1'h0, a, 8'h00, a == 8'h67 ? 8'h0C : a == 8'h73 ? 8'h01 : a == 8'h74 ? 8'h03 : 8'h00);
    end
    for (int i = 8'h67; i <= 8'h7B; i++) begin
      a = i[7:0];
      d = 8'($random(seed));
      bus(1'h1, a, d, 8'h00);
      bus(1'h0, a, 8'h00, a == 8'h73 ? 8'h01 : d & rmask(a));
      // Slew field of the register just written
      s = a == 8'h74 ? SLEW0 : a == 8'h76 ? SLEW1 : a == 8'h77 ? OUTPUT2_SLEW_CTRL : a == 8'h78 ? SLEW3 :
          a == 8'h79 ? SLEW4 : a == 8'h7A ? SLEW5 : OUTPUT6_SLEW_CTRL;
      if (a > 8'h75 || a == 8'h74) begin
        check({14'h0000, s}, {14'h0000, a == 8'h7B ? d[7:6] : d[5:4]});
      end
    end
    for (int i = 0; i < 6; i++) begin
      lo[i] = 8'($random(seed));
      rd[i] = (i == 3) ? 8'h00 : 8'($random(seed));
      bus(1'h1, 8'h68 + 8'(i), lo[i], 8'h00);
      if (i != 3) bus(1'h1, i < 3 ? 8'h70 + 8'(i) : 8'h6A + 8'(i), rd[i], 8'h00);
    end
    // Selections 6 and 7 fall back to set 0
    for (int i = 0; i < 8; i++) begin
      CFG_SEL = 3'(i);
      SS_FB_HIGH = 8'($random(seed));
      idle(2);
      check(SS_LOOP_COUNT, {SS_FB_HIGH, lo[i > 5 ? 0 : i]});
      check({8'h00, SS_REF_DIV}, {8'h00, rd[i > 5 ? 0 : i]});
    end
    for (int i = 0; i < 3; i++) begin
      FB_HIGH_SET3 = (i == 2) ? 4'hA : 4'h0;
      bus(1'h1, 8'h67, i == 0 ? 8'h0B : i == 1 ? 8'h0C : 8'h20, 8'h00);
      idle(2);
      check({4'h0, FB_COUNT_SET3}, i == 2 ? 16'h0A20 : 16'h000C);
      check({15'h0000, FB_SET3_CLAMPED}, {15'h0000, i == 0});
    end
    for (int k = 0; k < 5; k++) bus(1'h1, ctl[k], k == 0 ? 8'h03 : 8'h00, 8'h00);
    for (int k = 0; k < 5; k++) begin
      for (int m = 0; m < 4; m++) begin
        bus(1'h1, ctl[k], {2'(m), 6'h00} | (k == 0 ? 8'h03 : 8'h00), 8'h00);
        idle(1);
        eo = gm[k] & {9{m == 3}};
        en = ~gm[k] | (gm[k] & {9{~m[0]}});
        check({7'h00, pin_n}, {7'h00, en});
        check({7'h00, line & ~en}, {7'h00, eo});
      end
      bus(1'h1, ctl[k], k == 0 ? 8'h03 : 8'h00, 8'h00);
    end
    // Clocks run once the enable pin settles
    OUT_EN_PIN = 1'h1;
    for (int w = 0; w < 20 && pin_n !== 9'h000; w++) idle(1);
    if (pin_n !== 9'h000) begin
      failures++;
      finish_test;
    end
    for (int t = 0; t < 8; t++) begin
      r = 9'($random(seed));
      s = t[1:0];
      bus(1'h1, 8'h74, {4'h0, r[0], 1'h0, s}, 8'h00);
      bus(1'h1, 8'h76, {4'h0, r[2:1], 2'h0}, 8'h00);
      bus(1'h1, 8'h78, {4'h0, r[4:3], 2'h0}, 8'h00);
      bus(1'h1, 8'h79, {4'h0, r[6:5], 2'h0}, 8'h00);
      bus(1'h1, 8'h7A, {4'h0, r[8:7], 2'h0}, 8'h00);
      repeat (4) begin
        idle(1);
        {DIV6_CLK, DIV5_CLK, DIV4_CLK, DIV3_CLK, DIV2_CLK, DIV1_CLK, DIV0_CLK} = 7'($random(seed));
        #1;
        eo = {DIV0_CLK, s[1] ? DIV1_CLK : DIV2_CLK, DIV2_CLK, s[0] ? DIV3_CLK : DIV6_CLK,
              DIV6_CLK, DIV4_CLK, ~DIV4_CLK, DIV5_CLK, ~DIV5_CLK};
        check({7'h00, line}, {7'h00, eo ^ {r[0], r[2], r[1], r[4], r[3], r[6], r[5], r[8], r[7]}});
      end
    end
    idle(3);
    // Mid-run reset: pins float again, routing back to reset
    SRST = 1'h1;
    idle(2);
    SRST = 1'h0;
    check({7'h00, pin_n}, 16'h01FF);
    bus(1'h0, 8'h74, 8'h00, 8'h03);
    idle(3);
    finish_test;
  end
endmodule
`default_nettype wire
